// ---- tec_trigger_combiner.sv ----
// Trigger event combiner: breakpoints, watchpoints, master trigger and JTAG config chain.
// Assumes TCK, TMS and TDI are already synchronous to I_CLOCK and far slower than it.
//
// Overview of operation
// (RULE1) Breakpoint fires while its branch is selected
// (RULE2) Nested branch ANDs all enclosing conditions, else negated
// (RULE3) Watchpoint fires on value or transition
// (RULE4) Watchpoint compares whole signal set as one
// (RULE5) Activated breakpoints are ORed together
// (RULE6) Activated watchpoints are ANDed together
// (RULE7) Breakpoint OR ANDed with watchpoint AND triggers
// (RULE8) Config via built-in or soft TAP
// (RULE9) Empty group counts as true; with both groups empty there is no trigger
module tec_trigger_combiner #(
    parameter bit USE_SOFT_TAP = 1'b0 // 1: soft TAP on TMS/TDI, 0: built-in TAP user strobes
) (
    input wire logic I_CLOCK,
    input wire logic I_RESET,
    input wire logic I_TCK,
    input wire logic I_TMS,
    input wire logic I_TDI,
    input wire logic I_USER_SHIFT,
    input wire logic I_USER_UPDATE,
    input wire logic [tec_pkg::NUM_BP*tec_pkg::COND_W-1:0] I_COND,
    input wire logic [tec_pkg::NUM_WP*tec_pkg::WATCH_W-1:0] I_WATCH,
    output logic O_TDO,
    output logic O_TRIGGER,
    output logic [tec_pkg::NUM_BP-1:0] O_BP_EVENT,
    output logic [tec_pkg::NUM_WP-1:0] O_WP_EVENT
);

    localparam int NBP = tec_pkg::NUM_BP;
    localparam int NWP = tec_pkg::NUM_WP;
    localparam int CW = tec_pkg::COND_W;
    localparam int WW = tec_pkg::WATCH_W;
    localparam int CHW = tec_pkg::CHAIN_W;

    // ==========================================================
    // JTAG front end
    logic tck_q;                     // TCK one sample back, for edge detection
    logic upd_q;                     // Built-in update strobe one sample back
    tec_pkg::tec_tap_e tap_state;    // Soft TAP state
    tec_pkg::tec_tap_e next_tap_state;
    logic [CHW-1:0] chain;           // Shift stage; activation does not move while shifting
    logic [CHW-1:0] cfg;             // Live configuration, loaded on update

    wire logic tck_rise = I_TCK && !tck_q;
    wire logic soft_shift = tck_rise && (tap_state == tec_pkg::TAP_SH_DR);
    wire logic soft_upd = tck_rise && I_TMS &&
        ((tap_state == tec_pkg::TAP_EX1_DR) || (tap_state == tec_pkg::TAP_EX2_DR));
    wire logic hard_shift = tck_rise && I_USER_SHIFT;
    wire logic hard_upd = I_USER_UPDATE && !upd_q;
    // Interface chosen at build time, not at run time
    wire logic shift_en = USE_SOFT_TAP ? soft_shift : hard_shift; // RULE8
    wire logic update_en = USE_SOFT_TAP ? soft_upd : hard_upd;   // RULE8

    // Soft TAP next state, walked on TMS at each TCK rise
    always_comb begin
        next_tap_state = tap_state;
        case (tap_state)
            tec_pkg::TAP_RESET: next_tap_state = I_TMS ? tec_pkg::TAP_RESET : tec_pkg::TAP_IDLE;
            tec_pkg::TAP_IDLE: next_tap_state = I_TMS ? tec_pkg::TAP_SEL_DR : tec_pkg::TAP_IDLE;
            tec_pkg::TAP_SEL_DR: next_tap_state = I_TMS ? tec_pkg::TAP_SEL_IR : tec_pkg::TAP_CAP_DR;
            tec_pkg::TAP_CAP_DR: next_tap_state = I_TMS ? tec_pkg::TAP_EX1_DR : tec_pkg::TAP_SH_DR;
            tec_pkg::TAP_SH_DR: next_tap_state = I_TMS ? tec_pkg::TAP_EX1_DR : tec_pkg::TAP_SH_DR;
            tec_pkg::TAP_EX1_DR: next_tap_state = I_TMS ? tec_pkg::TAP_UPD_DR : tec_pkg::TAP_PAU_DR;
            tec_pkg::TAP_PAU_DR: next_tap_state = I_TMS ? tec_pkg::TAP_EX2_DR : tec_pkg::TAP_PAU_DR;
            tec_pkg::TAP_EX2_DR: next_tap_state = I_TMS ? tec_pkg::TAP_UPD_DR : tec_pkg::TAP_SH_DR;
            tec_pkg::TAP_UPD_DR: next_tap_state = I_TMS ? tec_pkg::TAP_SEL_DR : tec_pkg::TAP_IDLE;
            tec_pkg::TAP_SEL_IR: next_tap_state = I_TMS ? tec_pkg::TAP_RESET : tec_pkg::TAP_CAP_IR;
            tec_pkg::TAP_CAP_IR: next_tap_state = I_TMS ? tec_pkg::TAP_EX1_IR : tec_pkg::TAP_SH_IR;
            tec_pkg::TAP_SH_IR: next_tap_state = I_TMS ? tec_pkg::TAP_EX1_IR : tec_pkg::TAP_SH_IR;
            tec_pkg::TAP_EX1_IR: next_tap_state = I_TMS ? tec_pkg::TAP_UPD_IR : tec_pkg::TAP_PAU_IR;
            tec_pkg::TAP_PAU_IR: next_tap_state = I_TMS ? tec_pkg::TAP_EX2_IR : tec_pkg::TAP_PAU_IR;
            tec_pkg::TAP_EX2_IR: next_tap_state = I_TMS ? tec_pkg::TAP_UPD_IR : tec_pkg::TAP_SH_IR;
            tec_pkg::TAP_UPD_IR: next_tap_state = I_TMS ? tec_pkg::TAP_SEL_DR : tec_pkg::TAP_IDLE;
            default: next_tap_state = tec_pkg::TAP_RESET;
        endcase
    end

    // Edge history and TAP state; instruction register is absent, one data path only
    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            tck_q <= 1'b0;
            upd_q <= 1'b0;
            tap_state <= tec_pkg::TAP_RESET;
        end else begin
            tck_q <= I_TCK;
            upd_q <= I_USER_UPDATE;
            if (tck_rise) begin
                tap_state <= next_tap_state;
            end
        end
    end

    // Shift and update; TDO shows the bit leaving the chain
    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            chain <= tec_pkg::CHAIN_RESET;
            cfg <= tec_pkg::CHAIN_RESET;
            O_TDO <= 1'b0;
        end else begin
            if (shift_en) begin
                chain <= {I_TDI, chain[CHW-1:1]}; // RULE8
            end
            if (update_en) begin
                cfg <= chain; // RULE8
            end
            O_TDO <= chain[0];
        end
    end

    // ==========================================================
    // Configuration fields
    wire logic [NBP-1:0] bp_act = cfg[tec_pkg::OFS_BP_ACT +: NBP];
    wire logic [NWP-1:0] wp_act = cfg[tec_pkg::OFS_WP_ACT +: NWP];
    logic [NBP-1:0] bp_hit; // Raw breakpoint events
    logic [NWP-1:0] wp_hit; // Raw watchpoint events

    // ==========================================================
    // Breakpoints and watchpoints
    generate
        for (genvar i = 0; i < NBP; i++) begin : g_bp
            // Mask selects enclosing conditions; polarity 1 for if side, 0 for else side
            wire logic [CW-1:0] mask = cfg[tec_pkg::OFS_BP_MASK + i*CW +: CW];
            wire logic [CW-1:0] pol = cfg[tec_pkg::OFS_BP_POL + i*CW +: CW];
            wire logic [CW-1:0] cond = I_COND[i*CW +: CW];
            assign bp_hit[i] = &(~mask | ~(cond ^ pol)); // RULE1 RULE2
        end
        for (genvar j = 0; j < NWP; j++) begin : g_wp
            tec_wp_if u_if();
            assign u_if.act = wp_act[j];
            assign u_if.mode = cfg[tec_pkg::OFS_WP_MODE + j];
            assign u_if.val_a = cfg[tec_pkg::OFS_WP_VA + j*WW +: WW];
            assign u_if.val_b = cfg[tec_pkg::OFS_WP_VB + j*WW +: WW];
            assign u_if.sig = I_WATCH[j*WW +: WW];
            assign wp_hit[j] = u_if.hit;
            tec_wp_unit u_wp (
                .i_clock(I_CLOCK),
                .i_reset(I_RESET),
                .wp(u_if.unit)
            );
        end
    endgenerate

    // ==========================================================
    // Combining; an empty group passes, but with nothing activated there is no trigger
    wire logic any_bp = |bp_act;
    wire logic any_wp = |wp_act;
    wire logic bp_or = |(bp_act & bp_hit);          // RULE5
    wire logic wp_and = &(~wp_act | wp_hit);        // RULE6
    wire logic bp_ok = any_bp ? bp_or : 1'b1;       // RULE9
    wire logic next_trigger = bp_ok && wp_and && (any_bp || any_wp); // RULE7

    // Registered outputs towards the sample buffer and counter
    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            O_TRIGGER <= 1'b0;
            O_BP_EVENT <= '0;
            O_WP_EVENT <= '0;
        end else begin
            O_TRIGGER <= next_trigger; // RULE7
            O_BP_EVENT <= bp_act & bp_hit;
            O_WP_EVENT <= wp_act & wp_hit;
        end
    end

    // ==========================================================
    // Checks
    AST_BP_BRANCH: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE1
        bp_act[0] && (((I_COND[CW-1:0] ^ g_bp[0].pol) & g_bp[0].mask) == '0) |=> O_BP_EVENT[0])
        else $error("Selected branch did not raise breakpoint event");

    AST_BP_NEST: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE2
        (((I_COND[CW-1:0] ^ g_bp[0].pol) & g_bp[0].mask) != '0) |=> !O_BP_EVENT[0])
        else $error("Breakpoint fired with an enclosing condition false");

    AST_BP_OR: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE5
        ((bp_act & bp_hit) != '0) && wp_and |=> O_TRIGGER)
        else $error("One active breakpoint did not trigger");

    AST_WP_AND: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE6
        ((wp_act & ~wp_hit) != '0) |=> !O_TRIGGER)
        else $error("Trigger with an active watchpoint false");

    AST_MASTER: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE7
        ##1 O_TRIGGER == $past(((bp_act & bp_hit) != '0 || !any_bp) && wp_and && (any_bp || any_wp)))
        else $error("Master trigger differs from combined events");

    AST_BP_ONLY: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE9
        !any_wp && any_bp |=> O_TRIGGER == $past(bp_or))
        else $error("Breakpoints alone did not decide trigger");

    AST_WP_ONLY: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE9
        !any_bp && any_wp && wp_and |=> O_TRIGGER)
        else $error("Watchpoints alone did not decide trigger");

    AST_CFG_LOAD: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE8
        update_en && !shift_en |=> (cfg == $past(chain)) ##1 $stable(cfg) || $past(update_en))
        else $error("Configuration not loaded from chain on update");

    AST_CFG_HOLD: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE8
        !update_en |=> $stable(cfg))
        else $error("Configuration changed without update");

    // Built-in shift: the TDI bit taken on a TCK rise enters the top of the chain
    AST_HARD_SHIFT: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE8
        (USE_SOFT_TAP == 1'b0) && tck_rise && I_USER_SHIFT |=> chain[CHW-1] == $past(I_TDI))
        else $error("Built-in shift did not take TDI");

    // Soft TAP leaves the shift state only on a TCK rise with TMS high
    AST_TAP_EXIT: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE8
        (tap_state == tec_pkg::TAP_SH_DR) && tck_rise && I_TMS
        |=> tap_state == tec_pkg::TAP_EX1_DR)
        else $error("Soft TAP did not leave shift on TMS high");

    // TDO shows the bit that leaves the chain next, one cycle late
    AST_TDO_TRACK: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE8
        ##1 O_TDO == $past(chain[0]))
        else $error("TDO does not follow the chain end");

    // Both groups empty: the master trigger stays low, nothing to capture on
    AST_NO_GROUP: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RULE9
        !any_bp && !any_wp |=> !O_TRIGGER)
        else $error("Trigger with nothing activated");

endmodule // tec_trigger_combiner

// ---- tec_pkg.sv ----
// Shared constants for the trigger event combiner: sizes, chain layout and TAP states.
// Assumes one sampling clock; all users refer to names as tec_pkg::name.
package tec_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_BP = 4;   // Breakpoint units
    localparam int COND_W = 8;   // Branch condition bits per breakpoint
    localparam int NUM_WP = 2;   // Watchpoint units
    localparam int WATCH_W = 8;  // Monitored bits per watchpoint

    // ==========================================================
    // Watchpoint modes
    localparam logic MODE_EQUAL = 1'b0; // Fire while signal equals value A
    localparam logic MODE_TRANS = 1'b1; // Fire on step from value A to value B

    // ==========================================================
    // Configuration chain layout, bit 0 is shifted out first
    localparam int OFS_BP_ACT = 0;
    localparam int OFS_BP_MASK = OFS_BP_ACT + NUM_BP;
    localparam int OFS_BP_POL = OFS_BP_MASK + NUM_BP * COND_W;
    localparam int OFS_WP_ACT = OFS_BP_POL + NUM_BP * COND_W;
    localparam int OFS_WP_MODE = OFS_WP_ACT + NUM_WP;
    localparam int OFS_WP_VA = OFS_WP_MODE + NUM_WP;
    localparam int OFS_WP_VB = OFS_WP_VA + NUM_WP * WATCH_W;
    localparam int CHAIN_W = OFS_WP_VB + NUM_WP * WATCH_W;
    localparam logic [CHAIN_W-1:0] CHAIN_RESET = '0; // Nothing activated after reset

    // ==========================================================
    // Soft TAP controller states
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SH_DR = 4'h4,
        TAP_EX1_DR = 4'h5,
        TAP_PAU_DR = 4'h6,
        TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'hA,
        TAP_SH_IR = 4'hB,
        TAP_EX1_IR = 4'hC,
        TAP_PAU_IR = 4'hD,
        TAP_EX2_IR = 4'hE,
        TAP_UPD_IR = 4'hF
    } tec_tap_e;

endpackage

// ---- tec_wp_if.sv ----
// Carrier between the combiner and one watchpoint unit.
// Assumes the combiner drives configuration and the monitored signal set.
interface tec_wp_if;
    logic act;                              // Watchpoint activated
    logic mode;                             // Equal or transition mode
    logic [tec_pkg::WATCH_W-1:0] val_a;     // Compare value or from value
    logic [tec_pkg::WATCH_W-1:0] val_b;     // To value
    logic [tec_pkg::WATCH_W-1:0] sig;       // Monitored signal set
    logic hit;                              // Unit event

    modport unit (input act, input mode, input val_a, input val_b, input sig, output hit);
    modport combiner (output act, output mode, output val_a, output val_b, output sig,
                      input hit);
endinterface

// ---- tec_wp_unit.sv ----
// One watchpoint unit: value match or value transition over a signal set.
// Assumes the monitored set is synchronous to the sampling clock.
module tec_wp_unit (
    input wire logic i_clock,
    input wire logic i_reset,
    tec_wp_if.unit wp
);

    // ==========================================================
    // Previous sample of the monitored set
    logic [tec_pkg::WATCH_W-1:0] prev; // Value one sampling cycle back
    logic prev_ok;                     // Prev holds a real sample, not the reset value

    // Whole set compared at once, never bit by bit
    wire logic now_a = (wp.sig == wp.val_a); // RULE4
    wire logic now_b = (wp.sig == wp.val_b);
    wire logic was_a = prev_ok && (prev == wp.val_a);

    // Mode select; event is valid whether or not the unit is activated
    assign wp.hit = (wp.mode == tec_pkg::MODE_EQUAL) ? now_a : (was_a && now_b); // RULE3

    // History register; prev_ok blocks a false transition out of reset
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            prev <= '0;
            prev_ok <= 1'b0;
        end else begin
            prev <= wp.sig;
            prev_ok <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    sequence s_from_a;
        wp.sig == wp.val_a;
    endsequence

    sequence s_to_b;
        (wp.sig == wp.val_b) && $stable(wp.val_a) && (wp.mode == tec_pkg::MODE_TRANS);
    endsequence

    AST_WP_EQUAL: assert property (@(posedge i_clock) disable iff (i_reset) // RULE3
        (wp.mode == tec_pkg::MODE_EQUAL) |-> (wp.hit == (wp.sig == wp.val_a)))
        else $error("Equal-mode watchpoint event wrong");

    AST_WP_TRANS: assert property (@(posedge i_clock) disable iff (i_reset) // RULE3
        s_from_a ##1 s_to_b |-> wp.hit)
        else $error("Transition A to B not reported");

    AST_WP_NOTRANS: assert property (@(posedge i_clock) disable iff (i_reset) // RULE3
        (wp.mode == tec_pkg::MODE_TRANS) && !$past(wp.sig == wp.val_a) |-> !wp.hit)
        else $error("Transition event without prior A value");

endmodule // tec_wp_unit

// ---- tec_capture_model.sv ----
// Sample buffer stand-in that sits behind the master trigger output.
// Assumes the trigger is a registered level on the sampling clock.
module tec_capture_model (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_trigger,
    output logic o_frozen,
    output logic [15:0] o_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Capture state
    // Freeze is sticky, like a buffer that stops writing on its event
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_frozen <= 1'b0;
            o_count <= 16'h0000;
        end else if (i_trigger) begin
            // Each trigger cycle would be one acquisition request
            o_frozen <= 1'b1;
            o_count <= o_count + 16'h0001;
        end
    end
endmodule // tec_capture_model

// ---- test_trigger_event_combiner.sv ----
// Self-checking bench for the trigger event combiner, built-in TAP copy and soft TAP copy.
// Assumes both copies share the link pins and a capture model on the built-in trigger.
module test_trigger_event_combiner;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Stimulus and observation
    logic clk;
    logic rst;
    logic tck;
    logic tms; // Walks the soft TAP; the built-in copy ignores it
    logic tdi;
    logic ushift;
    logic uupd;
    logic [tec_pkg::NUM_BP*tec_pkg::COND_W-1:0] cond;
    logic [tec_pkg::NUM_WP*tec_pkg::WATCH_W-1:0] watch;
    logic tdo;
    logic trig;
    logic [tec_pkg::NUM_BP-1:0] bpev;
    logic [tec_pkg::NUM_WP-1:0] wpev;
    logic frozen;
    logic [15:0] trig_count; // Trigger cycles seen by the capture model
    logic s_tdo; // Soft TAP copy outputs
    logic s_trig;
    logic [tec_pkg::NUM_BP-1:0] s_bpev;
    logic [tec_pkg::CHAIN_W-1:0] cfg; // Configuration image to shift in
    int num_errors = 0;
    int n_checks = 0;

    tec_trigger_combiner dut (.I_CLOCK(clk), .I_RESET(rst), .I_TCK(tck), .I_TMS(tms),
        .I_TDI(tdi), .I_USER_SHIFT(ushift), .I_USER_UPDATE(uupd), .I_COND(cond),
        .I_WATCH(watch), .O_TDO(tdo), .O_TRIGGER(trig), .O_BP_EVENT(bpev),
        .O_WP_EVENT(wpev));

    // Second copy built with the soft TAP; it shares every input with the first
    tec_trigger_combiner #(.USE_SOFT_TAP(1'b1)) dut_soft (.I_CLOCK(clk), .I_RESET(rst),
        .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi), .I_USER_SHIFT(ushift), .I_USER_UPDATE(uupd),
        .I_COND(cond), .I_WATCH(watch), .O_TDO(s_tdo), .O_TRIGGER(s_trig),
        .O_BP_EVENT(s_bpev), .O_WP_EVENT());

    tec_capture_model buffer_model (.i_clock(clk), .i_reset(rst), .i_trigger(trig),
        .o_frozen(frozen), .o_count(trig_count));

    // ==========================================================
    // Clock: 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic set_bp(input int i, input logic [7:0] mask, input logic [7:0] pol);
        cfg[tec_pkg::OFS_BP_ACT + i] = 1'b1;
        cfg[tec_pkg::OFS_BP_MASK + tec_pkg::COND_W*i +: 8] = mask;
        cfg[tec_pkg::OFS_BP_POL + tec_pkg::COND_W*i +: 8] = pol;
    endtask

    task automatic set_wp(input int j, input logic mode, input logic [7:0] a,
            input logic [7:0] b);
        cfg[tec_pkg::OFS_WP_ACT + j] = 1'b1;
        cfg[tec_pkg::OFS_WP_MODE + j] = mode;
        cfg[tec_pkg::OFS_WP_VA + tec_pkg::WATCH_W*j +: 8] = a;
        cfg[tec_pkg::OFS_WP_VB + tec_pkg::WATCH_W*j +: 8] = b;
    endtask

    // One TCK period of two sampling cycles, TMS and TDI set up with the rise
    task automatic tck_pulse(input logic m, input logic d);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        tck <= 1'b1;
        @(posedge clk);
        tck <= 1'b0;
    endtask

    // Shift the whole image LSB first, one TCK rise per bit, then update
    task automatic load_cfg;
        int k;
        @(posedge clk);
        ushift <= 1'b1;
        for (k = 0; k < tec_pkg::CHAIN_W; k++) begin
            tck_pulse(1'b0, cfg[k]);
        end
        @(posedge clk);
        ushift <= 1'b0;
        uupd <= 1'b1;
        @(posedge clk);
        uupd <= 1'b0;
        @(posedge clk);
        chk("tdo", {7'h00, cfg[0]}, {7'h00, tdo});
    endtask

    // Present one input set; outputs answer on the next edge, the one that samples it
    task automatic apply(input logic [31:0] c, input logic [15:0] w, input logic [3:0] e_bp,
            input logic [1:0] e_wp, input logic e_trig);
        @(posedge clk);
        cond <= c;
        watch <= w;
        @(posedge clk);
        #1;
        chk("bp_event", {4'h0, e_bp}, {4'h0, bpev});
        chk("wp_event", {6'h00, e_wp}, {6'h00, wpev});
        chk("trigger", {7'h00, e_trig}, {7'h00, trig});
    endtask

    // ==========================================================
    // Scenarios
    // Nothing activated: no event even with every input high
    task automatic test_reset;
        apply({4{8'hFF}}, 16'hFFFF, 4'h0, 2'b00, 1'b0);
        $display("test reset done");
    endtask

    // Outer if, nested if and its else; bp3 inactive with empty mask
    task automatic test_breakpoints;
        cfg = '0;
        set_bp(0, 8'h01, 8'h01);
        set_bp(1, 8'h03, 8'h03);
        set_bp(2, 8'h03, 8'h01);
        load_cfg();
        apply({4{8'h03}}, 16'h0000, 4'b0011, 2'b00, 1'b1);
        apply({4{8'h01}}, 16'h0000, 4'b0101, 2'b00, 1'b1);
        apply({4{8'h02}}, 16'h0000, 4'b0000, 2'b00, 1'b0);
        $display("test breakpoints done");
    endtask

    // Two equal-mode watchpoints must match together; one stray bit breaks it
    task automatic test_watch_equal;
        cfg = '0;
        set_wp(0, tec_pkg::MODE_EQUAL, 8'h17, 8'h00);
        set_wp(1, tec_pkg::MODE_EQUAL, 8'h01, 8'h00);
        load_cfg();
        apply(32'h0000_0000, 16'h0117, 4'h0, 2'b11, 1'b1);
        apply(32'h0000_0000, 16'h0116, 4'h0, 2'b10, 1'b0);
        apply(32'h0000_0000, 16'h0017, 4'h0, 2'b01, 1'b0);
        $display("test watch equal done");
    endtask

    // Transition watchpoint ANDed with a breakpoint
    task automatic test_transition;
        logic [15:0] c0;
        cfg = '0;
        set_bp(0, 8'h01, 8'h01);
        set_wp(0, tec_pkg::MODE_TRANS, 8'h5A, 8'hA5);
        load_cfg();
        apply({4{8'h01}}, 16'h005A, 4'b0001, 2'b00, 1'b0);
        c0 = trig_count;
        apply({4{8'h01}}, 16'h00A5, 4'b0001, 2'b01, 1'b1);
        apply({4{8'h01}}, 16'h00A5, 4'b0001, 2'b00, 1'b0);
        // One step from A to B is one trigger cycle, even if B is held
        chk("trigger_count", 8'h01, 8'(trig_count - c0));
        apply({4{8'h00}}, 16'h005A, 4'b0000, 2'b00, 1'b0);
        apply({4{8'h00}}, 16'h00A5, 4'b0000, 2'b01, 1'b0);
        $display("test transition done");
    endtask

    // Breakpoint image loaded by walking the soft TAP from idle; the built-in copy
    // sees no shift strobe and keeps its own configuration
    task automatic test_soft_tap;
        int k;
        cfg = '0;
        set_bp(0, 8'h01, 8'h01);
        tck_pulse(1'b0, 1'b0);
        tck_pulse(1'b1, 1'b0);
        tck_pulse(1'b0, 1'b0);
        tck_pulse(1'b0, 1'b0);
        for (k = 0; k < tec_pkg::CHAIN_W; k++) begin
            tck_pulse(k == tec_pkg::CHAIN_W - 1, cfg[k]);
        end
        tck_pulse(1'b1, 1'b0);
        tck_pulse(1'b0, 1'b0);
        chk("soft_tdo", {7'h00, cfg[0]}, {7'h00, s_tdo});
        @(posedge clk);
        cond <= {4{8'h01}};
        watch <= 16'h0000;
        @(posedge clk);
        #1;
        chk("soft_bp_event", 8'h01, {4'h0, s_bpev});
        chk("soft_trigger", 8'h01, {7'h00, s_trig});
        @(posedge clk);
        cond <= '0;
        @(posedge clk);
        #1;
        chk("soft_trigger", 8'h00, {7'h00, s_trig});
        $display("test soft tap done");
    endtask

    // ==========================================================
    // Verdict, the single place where the run ends
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog: four chain loads take about 900 cycles
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        end_sim();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        tck = 1'b0;
        tms = 1'b0;
        tdi = 1'b0;
        ushift = 1'b0;
        uupd = 1'b0;
        cond = '0;
        watch = '0;
        cfg = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_breakpoints();
        test_watch_equal();
        test_transition();
        test_soft_tap();
        chk("frozen", 8'h01, {7'h00, frozen});
        end_sim();
    end
endmodule // test_trigger_event_combiner
